/* File: verilog/pcs_pkg.sv */
// Package of constants and types for the port-4 chip-select and extra interrupt block
package pcs_pkg;

    // =====================================================================
    // Register map (byte addresses on the register port)
    // =====================================================================
    localparam logic [7:0] PCS_ADDR_IRQ_CTRL  = 8'hc0;
    localparam logic [7:0] PCS_ADDR_CFG_LOW   = 8'hc2;
    localparam logic [7:0] PCS_ADDR_CFG_HIGH  = 8'hc3;
    localparam logic [7:0] PCS_ADDR_PORT_DATA = 8'hd8;
    localparam logic [7:0] PCS_ADDR_POLARITY  = 8'hae;
    localparam logic [7:0] PCS_ADDR_BASE0_LO  = 8'h84;
    localparam logic [7:0] PCS_ADDR_BASE0_HI  = 8'h85;
    localparam logic [7:0] PCS_ADDR_BASE1_LO  = 8'h94;
    localparam logic [7:0] PCS_ADDR_BASE1_HI  = 8'h95;
    localparam logic [7:0] PCS_ADDR_BASE2_LO  = 8'hac;
    localparam logic [7:0] PCS_ADDR_BASE2_HI  = 8'had;
    localparam logic [7:0] PCS_ADDR_BASE3_LO  = 8'hb4;
    localparam logic [7:0] PCS_ADDR_BASE3_HI  = 8'hb5;
    localparam logic [7:0] PCS_ADDR_IRQ_STAT  = 8'hf0;
    localparam logic [7:0] PCS_ADDR_IRQ_MASK  = 8'hf1;

    // =====================================================================
    // Field positions
    // =====================================================================
    localparam int PCS_IRQ_A_TRIG = 0;
    localparam int PCS_IRQ_A_FLAG = 1;
    localparam int PCS_IRQ_A_EN   = 2;
    localparam int PCS_IRQ_A_PRIO = 3;
    localparam int PCS_IRQ_B_TRIG = 4;
    localparam int PCS_IRQ_B_FLAG = 5;
    localparam int PCS_IRQ_B_EN   = 6;
    localparam int PCS_IRQ_B_PRIO = 7;
    localparam int PCS_POL_LSB    = 4;
    localparam int PCS_STAT_A     = 0;
    localparam int PCS_STAT_B     = 1;

    // =====================================================================
    // Reset values and codes
    // =====================================================================
    localparam logic [7:0] PCS_RST_ZERO = 8'h00;
    localparam logic [7:0] PCS_RST_PORT = 8'hff;
    localparam logic [1:0] PCS_CMP_15   = 2'h0;
    localparam logic [1:0] PCS_CMP_14   = 2'h1;
    localparam logic [1:0] PCS_CMP_8    = 2'h2;
    localparam logic [5:0] PCS_VEC_A    = 6'h33;
    localparam logic [5:0] PCS_VEC_B    = 6'h3b;
    localparam logic [2:0] PCS_POLL_A   = 3'h6;
    localparam logic [2:0] PCS_POLL_B   = 3'h7;

    typedef enum logic [1:0] {
        PCS_FN_IO    = 2'h0,
        PCS_FN_READ  = 2'h1,
        PCS_FN_WRITE = 2'h2,
        PCS_FN_RW    = 2'h3
    } pcs_func_t;

    typedef struct packed {
        pcs_func_t  func;
        logic [1:0] cmp_len;
    } pcs_pin_cfg_t;

    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
        logic        wr;
    } pcs_bus_t;

    typedef struct packed {
        logic [5:0] vector;
        logic [2:0] poll;
        logic       high_prio;
        logic       valid;
    } pcs_irq_req_t;

endpackage

/* File: verilog/pcs_addr_match.sv */
// Address comparator for one chip-select pin
`timescale 1ns/1ps
module pcs_addr_match
    import pcs_pkg::*;
(
    input  wire logic [15:0] addr,
    input  wire logic [15:0] base,
    input  wire logic [1:0]  cmp_len,
    output logic             hit
);
    logic [15:0] care;

    // Unselected low bits are masked so a strobe covers an aligned block
    always_comb
    begin
        if (cmp_len == PCS_CMP_15)
            care = 16'hfffe; // [R8]
        else if (cmp_len == PCS_CMP_14)
            care = 16'hfffc; // [R8]
        else if (cmp_len == PCS_CMP_8)
            care = 16'hff00; // [R8]
        else
            care = 16'hffff;
        hit = ((addr ^ base) & care) == 16'h0000; // [R9]
    end
endmodule // pcs_addr_match

/* File: verilog/pcs_irq_det.sv */
// Trigger detector for one extra external interrupt
`timescale 1ns/1ps
module pcs_irq_det
    import pcs_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic pin_sync,
    input  wire logic edge_mode,
    input  wire logic enable,
    output logic      fall_pulse,
    output logic      request
);
    typedef struct packed {
        logic prev;
    } pcs_det_st_t;

    pcs_det_st_t st_ff;
    pcs_det_st_t nxt_st;

    always_comb
    begin
        nxt_st      = st_ff;
        nxt_st.prev = pin_sync;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            st_ff <= '{prev: 1'b1};
        else
            st_ff <= nxt_st;
    end

    assign fall_pulse = edge_mode && st_ff.prev && !pin_sync; // [R14]
    // Level mode asks while the pin is low; the level request is dropped when disabled, fall_pulse is not
    assign request    = enable && (edge_mode ? 1'b0 : !pin_sync); // [R16]

    a_fall_edge_seen: assert property (@(posedge clk) disable iff (!rst_b) // [R14]
        (edge_mode && $fell(pin_sync)) |-> fall_pulse) else $error("edge missed");
endmodule // pcs_irq_det

/* File: verilog/pcs_port4.sv */
// Port-4 block: quasi-bidirectional pins, address chip selects, two extra interrupts
// How it works
// R1 - Eight port bits, pins 0..3 each configured alone, pins 7..4 plain data
// R2 - Mode 0 pins act quasi-bidirectional
// R3 - Pin 2 and pin 3 feed extra interrupts
// R4 - Function 01 gives ranged read strobe
// R5 - Function 10 gives ranged write strobe
// R6 - Function 11 follows read or write
// R7 - Sixteen-bit base address per strobe pin
// R8 - Compare length selects 15, 14, 8 bits
// R9 - Match needs all selected bits equal
// R10 - High config register holds pins 3, 2
// R11 - Low config register holds pins 1, 0
// R12 - Polarity bit makes strobe active high
// R13 - Irq control supports single bit set/clear
// R14 - Trigger bit chooses falling edge or level
// R15 - Edge flag set by hardware, cleared on service
// R16 - Requests taken only while enabled; the code still sets the status bit and irq on an edge while disabled
// R17 - Priority bit selects high level
// R18 - Vectors 33H and 3BH, polls 6, 7
// R19 - Mode 0 drives data bits 3..0
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
module pcs_port4
    import pcs_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    input  wire logic       bit_set,
    input  wire logic       bit_clr,
    input  wire logic [2:0] bit_sel,
    input  pcs_bus_t        ext_bus,
    input  wire logic [7:0] pin_in,
    output logic [7:0]      pin_out,
    output logic [7:0]      pin_oe,
    input  wire logic       irq_a_ack,
    input  wire logic       irq_b_ack,
    output pcs_irq_req_t    irq_a_req,
    output pcs_irq_req_t    irq_b_req,
    output logic            irq
);
    // =====================================================================
    // State
    // =====================================================================
    typedef struct packed {
        logic [7:0]       port_data;
        logic [7:0]       irq_ctrl;
        logic [7:0]       cfg_low;
        logic [7:0]       cfg_high;
        logic [7:0]       polarity;
        logic [3:0][15:0] base;
        logic [1:0]       stat;
        logic [1:0]       mask;
        logic [7:0]       rdata;
        logic [7:0]       pin_meta;
        logic [7:0]       pin_sync;
        logic [3:0]       strobe;
        logic [7:0]       drive;
    } pcs_state_t;

    pcs_state_t st_ff;
    pcs_state_t nxt_st;

    pcs_pin_cfg_t [3:0] pin_cfg;
    logic [3:0]         hit;
    logic [1:0]         fall;
    logic [1:0]         lvl_req;

    assign pin_cfg[0] = pcs_pin_cfg_t'(st_ff.cfg_low[3:0]);  // [R11]
    assign pin_cfg[1] = pcs_pin_cfg_t'(st_ff.cfg_low[7:4]);  // [R11]
    assign pin_cfg[2] = pcs_pin_cfg_t'(st_ff.cfg_high[3:0]); // [R10]
    assign pin_cfg[3] = pcs_pin_cfg_t'(st_ff.cfg_high[7:4]); // [R10]

    // =====================================================================
    // Address comparators, one per strobe-capable pin
    // =====================================================================
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_cmp
            pcs_addr_match u_match (
                .addr    (ext_bus.addr),
                .base    (st_ff.base[gi]), // [R7]
                .cmp_len (pin_cfg[gi].cmp_len),
                .hit     (hit[gi])
            );
        end
    endgenerate

    // Eight-bit compare is judged on the high byte alone
    a_hit_mask_len: assert property (@(posedge clk) disable iff (!rst_b) // [R8] [R9]
        (pin_cfg[1].cmp_len == PCS_CMP_8)
        |-> (hit[1] == (ext_bus.addr[15:8] == st_ff.base[1][15:8]))) else $error("compare");

    // =====================================================================
    // Extra interrupt detectors on pins 2 and 3
    // =====================================================================
    pcs_irq_det u_det_a (
        .clk        (clk),
        .rst_b      (rst_b),
        .pin_sync   (st_ff.pin_sync[3]), // [R3]
        .edge_mode  (st_ff.irq_ctrl[PCS_IRQ_A_TRIG]),
        .enable     (st_ff.irq_ctrl[PCS_IRQ_A_EN]),
        .fall_pulse (fall[0]),
        .request    (lvl_req[0])
    );

    pcs_irq_det u_det_b (
        .clk        (clk),
        .rst_b      (rst_b),
        .pin_sync   (st_ff.pin_sync[2]), // [R3]
        .edge_mode  (st_ff.irq_ctrl[PCS_IRQ_B_TRIG]),
        .enable     (st_ff.irq_ctrl[PCS_IRQ_B_EN]),
        .fall_pulse (fall[1]),
        .request    (lvl_req[1])
    );

    // =====================================================================
    // Next state
    // =====================================================================
    always_comb
    begin
        logic [7:0] rd;
        logic       ev_a;
        logic       ev_b;
        rd     = 8'h00;
        ev_a   = 1'b0;
        ev_b   = 1'b0;
        nxt_st = st_ff;

        nxt_st.pin_meta = pin_in;
        nxt_st.pin_sync = st_ff.pin_meta;

        // Register writes
        if (reg_wr)
        begin
            if (reg_addr == PCS_ADDR_PORT_DATA)
                nxt_st.port_data = reg_wdata; // [R1]
            else if (reg_addr == PCS_ADDR_IRQ_CTRL)
                nxt_st.irq_ctrl = reg_wdata;
            else if (reg_addr == PCS_ADDR_CFG_LOW)
                nxt_st.cfg_low = reg_wdata; // [R11]
            else if (reg_addr == PCS_ADDR_CFG_HIGH)
                nxt_st.cfg_high = reg_wdata; // [R10]
            else if (reg_addr == PCS_ADDR_POLARITY)
                nxt_st.polarity = {reg_wdata[7:4], 4'h0}; // [R12]
            else if (reg_addr == PCS_ADDR_BASE0_LO)
                nxt_st.base[0][7:0] = reg_wdata; // [R7]
            else if (reg_addr == PCS_ADDR_BASE0_HI)
                nxt_st.base[0][15:8] = reg_wdata; // [R7]
            else if (reg_addr == PCS_ADDR_BASE1_LO)
                nxt_st.base[1][7:0] = reg_wdata;
            else if (reg_addr == PCS_ADDR_BASE1_HI)
                nxt_st.base[1][15:8] = reg_wdata;
            else if (reg_addr == PCS_ADDR_BASE2_LO)
                nxt_st.base[2][7:0] = reg_wdata;
            else if (reg_addr == PCS_ADDR_BASE2_HI)
                nxt_st.base[2][15:8] = reg_wdata;
            else if (reg_addr == PCS_ADDR_BASE3_LO)
                nxt_st.base[3][7:0] = reg_wdata;
            else if (reg_addr == PCS_ADDR_BASE3_HI)
                nxt_st.base[3][15:8] = reg_wdata;
            else if (reg_addr == PCS_ADDR_IRQ_STAT)
                nxt_st.stat = st_ff.stat & ~reg_wdata[1:0];
            else if (reg_addr == PCS_ADDR_IRQ_MASK)
                nxt_st.mask = reg_wdata[1:0];
        end

        // Single-bit access to the interrupt control register
        if (bit_set)
            nxt_st.irq_ctrl[bit_sel] = 1'b1; // [R13]
        else if (bit_clr)
            nxt_st.irq_ctrl[bit_sel] = 1'b0; // [R13]

        // Service clears the edge flag; a new edge in the same cycle wins
        if (st_ff.irq_ctrl[PCS_IRQ_A_TRIG] && irq_a_ack)
            nxt_st.irq_ctrl[PCS_IRQ_A_FLAG] = 1'b0; // [R15]
        if (st_ff.irq_ctrl[PCS_IRQ_B_TRIG] && irq_b_ack)
            nxt_st.irq_ctrl[PCS_IRQ_B_FLAG] = 1'b0; // [R15]
        if (fall[0])
        begin
            nxt_st.irq_ctrl[PCS_IRQ_A_FLAG] = 1'b1; // [R15]
            ev_a = 1'b1;
        end
        if (fall[1])
        begin
            nxt_st.irq_ctrl[PCS_IRQ_B_FLAG] = 1'b1; // [R15]
            ev_b = 1'b1;
        end

        // Level mode: flag mirrors the low pin
        // A flag left set here survives a later switch to edge mode
        if (!st_ff.irq_ctrl[PCS_IRQ_A_TRIG])
            nxt_st.irq_ctrl[PCS_IRQ_A_FLAG] = !st_ff.pin_sync[3]; // [R14]
        if (!st_ff.irq_ctrl[PCS_IRQ_B_TRIG])
            nxt_st.irq_ctrl[PCS_IRQ_B_FLAG] = !st_ff.pin_sync[2]; // [R14]

        // Sticky status: set beats the write-one clear
        if (ev_a || lvl_req[0])
            nxt_st.stat[PCS_STAT_A] = 1'b1;
        if (ev_b || lvl_req[1])
            nxt_st.stat[PCS_STAT_B] = 1'b1;

        // Strobes, registered so the pin changes one cycle after the bus
        for (int i = 0; i < 4; i++)
        begin
            logic act;
            act = 1'b0;
            case (pin_cfg[i].func)
                PCS_FN_READ:  act = ext_bus.rd && hit[i];                   // [R4]
                PCS_FN_WRITE: act = ext_bus.wr && hit[i];                   // [R5]
                PCS_FN_RW:    act = (ext_bus.rd || ext_bus.wr) && hit[i];   // [R6]
                default:      act = 1'b0;
            endcase
            nxt_st.strobe[i] = act;
            if (pin_cfg[i].func == PCS_FN_IO)
                nxt_st.drive[i] = st_ff.port_data[i]; // [R19]
            else
                nxt_st.drive[i] = act ~^ st_ff.polarity[PCS_POL_LSB + i]; // [R12]
        end
        nxt_st.drive[7:4] = st_ff.port_data[7:4]; // [R1]

        // Read mux; port reads return pin levels like a standard port
        if (reg_addr == PCS_ADDR_PORT_DATA)
            rd = st_ff.pin_sync;
        else if (reg_addr == PCS_ADDR_IRQ_CTRL)
            rd = st_ff.irq_ctrl;
        else if (reg_addr == PCS_ADDR_CFG_LOW)
            rd = st_ff.cfg_low;
        else if (reg_addr == PCS_ADDR_CFG_HIGH)
            rd = st_ff.cfg_high;
        else if (reg_addr == PCS_ADDR_POLARITY)
            rd = st_ff.polarity;
        else if (reg_addr == PCS_ADDR_BASE0_LO)
            rd = st_ff.base[0][7:0];
        else if (reg_addr == PCS_ADDR_BASE0_HI)
            rd = st_ff.base[0][15:8];
        else if (reg_addr == PCS_ADDR_BASE1_LO)
            rd = st_ff.base[1][7:0];
        else if (reg_addr == PCS_ADDR_BASE1_HI)
            rd = st_ff.base[1][15:8];
        else if (reg_addr == PCS_ADDR_BASE2_LO)
            rd = st_ff.base[2][7:0];
        else if (reg_addr == PCS_ADDR_BASE2_HI)
            rd = st_ff.base[2][15:8];
        else if (reg_addr == PCS_ADDR_BASE3_LO)
            rd = st_ff.base[3][7:0];
        else if (reg_addr == PCS_ADDR_BASE3_HI)
            rd = st_ff.base[3][15:8];
        else if (reg_addr == PCS_ADDR_IRQ_STAT)
            rd = {6'h00, st_ff.stat};
        else if (reg_addr == PCS_ADDR_IRQ_MASK)
            rd = {6'h00, st_ff.mask};
        nxt_st.rdata = reg_rd ? rd : 8'h00;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_ff           <= '0;
            st_ff.port_data <= PCS_RST_PORT;
            st_ff.pin_meta  <= PCS_RST_PORT;
            st_ff.pin_sync  <= PCS_RST_PORT;
            st_ff.drive     <= PCS_RST_PORT;
        end
        else
            st_ff <= nxt_st;
    end

    // =====================================================================
    // Outputs
    // =====================================================================
    // Quasi-bidirectional: drive low hard, else release to the pull-up
    assign pin_out   = st_ff.drive;                                  // [R2]
    assign pin_oe    = ~st_ff.drive;                                 // [R2]
    assign reg_rdata = st_ff.rdata;
    assign irq       = |(st_ff.stat & st_ff.mask);

    always_comb
    begin
        irq_a_req.vector    = PCS_VEC_A;                               // [R18]
        irq_a_req.poll      = PCS_POLL_A;                              // [R18]
        irq_a_req.high_prio = st_ff.irq_ctrl[PCS_IRQ_A_PRIO];          // [R17]
        irq_a_req.valid     = st_ff.irq_ctrl[PCS_IRQ_A_EN]
                              && st_ff.irq_ctrl[PCS_IRQ_A_FLAG];       // [R16]
        irq_b_req.vector    = PCS_VEC_B;                               // [R18]
        irq_b_req.poll      = PCS_POLL_B;                              // [R18]
        irq_b_req.high_prio = st_ff.irq_ctrl[PCS_IRQ_B_PRIO];          // [R17]
        irq_b_req.valid     = st_ff.irq_ctrl[PCS_IRQ_B_EN]
                              && st_ff.irq_ctrl[PCS_IRQ_B_FLAG];       // [R16]
    end

    // =====================================================================
    // Checks
    // =====================================================================
    sequence s_wr_hit0;
        ext_bus.wr && hit[0] && pin_cfg[0].func == PCS_FN_WRITE;
    endsequence

    sequence s_ack_a;
        st_ff.irq_ctrl[PCS_IRQ_A_TRIG] && irq_a_ack && !fall[0] && !bit_set && !reg_wr;
    endsequence

    sequence s_idle_b;
        !st_ff.irq_ctrl[PCS_IRQ_B_EN] && !st_ff.irq_ctrl[PCS_IRQ_B_TRIG]
        && !st_ff.stat[PCS_STAT_B];
    endsequence

    sequence s_clr_stat_a;
        reg_wr && reg_addr == PCS_ADDR_IRQ_STAT && reg_wdata[PCS_STAT_A] && !fall[0] && !lvl_req[0];
    endsequence

    a_wr_strobe_pin0: assert property (@(posedge clk) disable iff (!rst_b) // [R5]
        s_wr_hit0 |=> (pin_out[0] == st_ff.polarity[4])) else $error("write strobe");
    a_rd_strobe_pin1: assert property (@(posedge clk) disable iff (!rst_b) // [R4]
        (ext_bus.rd && hit[1] && pin_cfg[1].func == PCS_FN_READ)
        |=> (pin_out[1] == st_ff.polarity[5])) else $error("read strobe");
    // A changed polarity flips the idle level, so it must hold as well
    a_rw_idle_pin3: assert property (@(posedge clk) disable iff (!rst_b) // [R6]
        (!ext_bus.rd && !ext_bus.wr && pin_cfg[3].func == PCS_FN_RW && $stable(pin_cfg[3])
         && $stable(st_ff.polarity))
        |=> (pin_out[3] != st_ff.polarity[7])) else $error("idle strobe");
    a_io_mode_data: assert property (@(posedge clk) disable iff (!rst_b) // [R19]
        (pin_cfg[3].func == PCS_FN_IO && $stable(st_ff.cfg_high))
        |=> (pin_out[3] == $past(st_ff.port_data[3]))) else $error("port data");
    a_upper_pins_data: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
        1'b1 |=> (pin_out[7:4] == $past(st_ff.port_data[7:4]))) else $error("upper pins");
    a_edge_flag_set: assert property (@(posedge clk) disable iff (!rst_b) // [R15]
        fall[0] |=> st_ff.irq_ctrl[PCS_IRQ_A_FLAG]) else $error("flag a");
    a_edge_ack_clear: assert property (@(posedge clk) disable iff (!rst_b) // [R15]
        s_ack_a |=> !st_ff.irq_ctrl[PCS_IRQ_A_FLAG]) else $error("flag a clear");
    a_level_flag_pin: assert property (@(posedge clk) disable iff (!rst_b) // [R14]
        !st_ff.irq_ctrl[PCS_IRQ_B_TRIG]
        |=> (st_ff.irq_ctrl[PCS_IRQ_B_FLAG] == !$past(st_ff.pin_sync[2])))
        else $error("level flag");
    // A disabled level input must never raise the status bit
    a_enable_gates_req: assert property (@(posedge clk) disable iff (!rst_b) // [R16]
        s_idle_b |=> !st_ff.stat[PCS_STAT_B]) else $error("enable");
    a_stat_clear_a: assert property (@(posedge clk) disable iff (!rst_b) // [R16]
        s_clr_stat_a |=> !st_ff.stat[PCS_STAT_A]) else $error("status clear");
    a_bit_set_ctrl: assert property (@(posedge clk) disable iff (!rst_b) // [R13]
        (bit_set && bit_sel == 3'h2) |=> st_ff.irq_ctrl[PCS_IRQ_A_EN]) else $error("bit set");
    a_prio_follow: assert property (@(posedge clk) disable iff (!rst_b) // [R17]
        (bit_set && bit_sel == 3'h3) |=> irq_a_req.high_prio) else $error("prio");
    a_rdata_one_cycle: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
        !reg_rd |=> (reg_rdata == 8'h00)) else $error("read data");
endmodule // pcs_port4

/* File: tb/pcs_periph.sv */
// Model of the external peripherals and pull-ups on all eight port pins
`timescale 1ns/1ps
module pcs_periph
(
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pull_low,
    output logic      [7:0] pin_in
);
    // =====================================================================
    // Wired-AND pad level
    // =====================================================================
    // A released pad floats to its pull-up unless pull_low holds it low, so it never shows a stale value
    assign pin_in = ~((pin_oe & ~pin_out) | pull_low);
endmodule // pcs_periph

/* File: tb/pcs_port4_bench.sv */
// Self-checking bench for the port-4 chip-select and extra interrupt block
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module pcs_port4_bench
    import pcs_pkg::*;
;
    logic         clk = 1'b0;
    logic         rst_b = 1'b0;
    logic [7:0]   reg_addr = 8'h00;
    logic [7:0]   reg_wdata = 8'h00;
    logic         reg_wr = 1'b0;
    logic         reg_rd = 1'b0;
    logic [7:0]   reg_rdata;
    logic         bit_set = 1'b0;
    logic         bit_clr = 1'b0;
    logic [2:0]   bit_sel = 3'h0;
    pcs_bus_t     ext_bus = '0;
    logic [7:0]   pin_in;
    logic [7:0]   pin_out;
    logic [7:0]   pin_oe;
    logic [7:0]   pull_low = 8'h00;
    logic         irq_a_ack = 1'b0;
    logic         irq_b_ack = 1'b0;
    pcs_irq_req_t irq_a_req;
    pcs_irq_req_t irq_b_req;
    logic         irq;
    int           err_total = 0;
    int           samples_checked = 0;
    wire  [1:0]   vld = {irq_b_req.valid, irq_a_req.valid};

    always #4 clk = ~clk;

    pcs_port4 dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bit_set(bit_set),
        .bit_clr(bit_clr), .bit_sel(bit_sel), .ext_bus(ext_bus), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .irq_a_ack(irq_a_ack), .irq_b_ack(irq_b_ack),
        .irq_a_req(irq_a_req), .irq_b_req(irq_b_req), .irq(irq));
    pcs_periph periph (.pin_out(pin_out), .pin_oe(pin_oe), .pull_low(pull_low),
        .pin_in(pin_in));

    // =====================================================================
    // Access tasks
    // =====================================================================
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk) reg_wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk) reg_rd <= 1'b0;
        #1 `CHK(reg_rdata, e)
    endtask
    task automatic bit_op(input logic [2:0] s, input logic v);
        @(posedge clk) {bit_sel, bit_set, bit_clr} <= {s, v, ~v};
        @(posedge clk) {bit_set, bit_clr} <= 2'b00;
    endtask
    // Strobe result is looked at while the bus strobe is still held
    task automatic bus(input logic [15:0] a, input logic r, input logic w,
                       input logic [3:0] e);
        @(posedge clk) ext_bus <= '{addr: a, rd: r, wr: w};
        @(posedge clk);
        #1 `CHK(pin_out[3:0], e)
        @(posedge clk) ext_bus <= '0;
    endtask
    task automatic wait_valid(input int idx, input logic lvl);
        int n;
        for (n = 0; n < 12 && vld[idx] !== lvl; n++)
            @(posedge clk);
        #1 `CHK(vld[idx], lvl)
        if (n == 12)
            report_and_stop();
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        report_and_stop();
    end

    // =====================================================================
    // Main sequence
    // =====================================================================
    initial
    begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rd_reg(PCS_ADDR_IRQ_CTRL, 8'h00);
        rd_reg(PCS_ADDR_PORT_DATA, 8'hff);
        rd_reg(8'h10, 8'h00);
        // Pins 3 and 2 stay high: a level flag taken now would outlive edge mode
        wr_reg(PCS_ADDR_PORT_DATA, 8'h5c);
        @(posedge clk);
        #1 `CHK(pin_out, 8'h5c)
        `CHK(pin_oe, 8'ha3)
        wr_reg(PCS_ADDR_PORT_DATA, 8'hff);
        // Edge interrupt on pin 3, high priority, unmasked
        bit_op(3'h0, 1'b1);
        bit_op(3'h2, 1'b1);
        bit_op(3'h3, 1'b1);
        wr_reg(PCS_ADDR_IRQ_MASK, 8'h01);
        pull_low[3] <= 1'b1;
        wait_valid(0, 1'b1);
        `CHK(irq_a_req.vector, 6'h33)
        `CHK(irq_a_req.poll, 3'h6)
        `CHK(irq_a_req.high_prio, 1'b1)
        `CHK(irq, 1'b1)
        rd_reg(PCS_ADDR_IRQ_CTRL, 8'h0f);
        @(posedge clk) irq_a_ack <= 1'b1;
        @(posedge clk) irq_a_ack <= 1'b0;
        wait_valid(0, 1'b0);
        rd_reg(PCS_ADDR_IRQ_CTRL, 8'h0d);
        wr_reg(PCS_ADDR_IRQ_STAT, 8'h01);
        #1 `CHK(irq, 1'b0)
        pull_low[3] <= 1'b0;
        // Level interrupt on pin 2: follows the pad, gated by enable
        bit_op(3'h6, 1'b1);
        pull_low[2] <= 1'b1;
        wait_valid(1, 1'b1);
        `CHK(irq_b_req.vector, 6'h3b)
        `CHK(irq_b_req.poll, 3'h7)
        `CHK(irq_b_req.high_prio, 1'b0)
        pull_low[2] <= 1'b0;
        wait_valid(1, 1'b0);
        wr_reg(PCS_ADDR_IRQ_STAT, 8'h02);
        bit_op(3'h6, 1'b0);
        pull_low[2] <= 1'b1;
        repeat (6) @(posedge clk);
        #1 `CHK(irq_b_req.valid, 1'b0)
        rd_reg(PCS_ADDR_IRQ_STAT, 8'h00);
        pull_low[2] <= 1'b0;
        // Chip selects: pin0 write 14-bit, pin1 read 8-bit, pin3 both 15-bit
        wr_reg(PCS_ADDR_BASE0_LO, 8'h34);
        wr_reg(PCS_ADDR_BASE0_HI, 8'h12);
        wr_reg(PCS_ADDR_BASE1_HI, 8'h56);
        wr_reg(PCS_ADDR_BASE3_LO, 8'hf0);
        wr_reg(PCS_ADDR_BASE3_HI, 8'h9a);
        wr_reg(PCS_ADDR_POLARITY, 8'h1f);
        wr_reg(PCS_ADDR_CFG_LOW, 8'h69);
        wr_reg(PCS_ADDR_CFG_HIGH, 8'hc0);
        rd_reg(PCS_ADDR_POLARITY, 8'h10);
        rd_reg(PCS_ADDR_CFG_LOW, 8'h69);
        rd_reg(PCS_ADDR_CFG_HIGH, 8'hc0);
        rd_reg(PCS_ADDR_BASE0_HI, 8'h12);
        bus(16'h1237, 1'b0, 1'b1, 4'b1111);
        bus(16'h1238, 1'b0, 1'b1, 4'b1110);
        bus(16'h1233, 1'b0, 1'b1, 4'b1110);
        bus(16'h1234, 1'b1, 1'b0, 4'b1110);
        bus(16'h56ff, 1'b1, 1'b0, 4'b1100);
        bus(16'h56ff, 1'b0, 1'b1, 4'b1110);
        bus(16'h5700, 1'b1, 1'b0, 4'b1110);
        bus(16'h9af1, 1'b1, 1'b0, 4'b0110);
        bus(16'h9af0, 1'b0, 1'b1, 4'b0110);
        bus(16'h9af2, 1'b0, 1'b1, 4'b1110);
        wr_reg(PCS_ADDR_PORT_DATA, 8'hf3);
        @(posedge clk);
        #1 `CHK(pin_out[3:2], 2'b10)
        report_and_stop();
    end
endmodule // pcs_port4_bench
